/* hw/sdl_pkg.sv */
/*
  Shared constants and state type for the serial load interface of an
  eight-channel converter.
  Assumes a single core clock domain that samples all serial pins.
*/
package sdl_pkg;

  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam int CH_N = 8;
  localparam int CH_W = 3;
  localparam int CH_LSB = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;
  localparam int PIN_N = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_LOAD_N = 3;
  localparam int PIN_WAKE_N = 4;
  localparam logic [PIN_N-1:0] PIN_RST = 5'h1B;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic {SDL_IDLE, SDL_SHIFT} sdl_phase_t;

  typedef struct packed {
    sdl_phase_t phase;
    logic [WORD_W-1:0] shreg;
    logic [CNT_W-1:0] bitcnt;
    logic sclk_q;
    logic cs_q;
    logic load_q;
    logic sleep;
    logic sdo;
    logic oe_n;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic async_mode;
    logic [CH_N-1:0][DATA_W-1:0] data;
    logic [CH_N-1:0][DATA_W-1:0] latch;
  } sdl_state_t;

  localparam sdl_state_t STATE_RST = '{
    phase: SDL_IDLE,
    shreg: 24'h000000,
    bitcnt: 5'h00,
    sclk_q: 1'b1,
    cs_q: 1'b1,
    load_q: 1'b1,
    sleep: 1'b0,
    sdo: 1'b0,
    oe_n: 1'b1,
    strap_cnt: 2'h0,
    strap_done: 1'b0,
    async_mode: 1'b0,
    data: '0,
    latch: '0
  };

endpackage : sdl_pkg

/* hw/sdl_sync.sv */
/*
  Two-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level or a clock sampled well above rate.
*/
`timescale 1ns/1ps
module sdl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= RST;
      sync_o <= RST;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : sdl_sync

/* hw/sdl_top.sv */
/*
  Serial host interface and output latch control of an eight-channel
  converter: frame reception, data registers, output latches, serial
  output driver with disable, daisy-chain sleep pass-through.
  Assumes the serial pins come from outside and are oversampled by the
  core clock; configuration inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module sdl_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic latch_load_n_i,
  input wire logic sleep_exit_n_i,
  input wire logic serial_out_disable_i,
  input wire logic daisy_chain_i,
  input wire logic sleep_enter_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic [sdl_pkg::CH_N*sdl_pkg::DATA_W-1:0] dac_value_o,
  output logic sleep_o,
  output logic async_mode_o
);

  sdl_pkg::sdl_state_t st_r;
  sdl_pkg::sdl_state_t st_nxt;
  logic [sdl_pkg::PIN_N-1:0] pin_s;
  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic load_s;
  logic wake_s;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_end;
  logic [sdl_pkg::CH_W-1:0] wr_ch;

  sdl_sync #(
    .W(sdl_pkg::PIN_N),
    .RST(sdl_pkg::PIN_RST)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i({sleep_exit_n_i, latch_load_n_i, sdi_i, cs_n_i, sclk_i}),
    .sync_o(pin_s)
  );

  assign sclk_s = pin_s[sdl_pkg::PIN_SCLK];
  assign cs_s = pin_s[sdl_pkg::PIN_CS_N];
  assign sdi_s = pin_s[sdl_pkg::PIN_SDI];
  assign load_s = pin_s[sdl_pkg::PIN_LOAD_N];
  assign wake_s = pin_s[sdl_pkg::PIN_WAKE_N];
  assign sclk_fall = st_r.sclk_q & ~sclk_s & ~cs_s;
  assign sclk_rise = ~st_r.sclk_q & sclk_s & ~cs_s;
  assign frame_end = ~st_r.cs_q & cs_s;
  assign wr_ch = st_r.shreg[sdl_pkg::CH_LSB +: sdl_pkg::CH_W];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclk_q = sclk_s;
    st_nxt.cs_q = cs_s;
    st_nxt.load_q = load_s;
    // The power-up level of latch load picks the update mode once.
    if (!st_r.strap_done)
    begin
      st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      if (st_r.strap_cnt == sdl_pkg::STRAP_WAIT)
      begin
        st_nxt.strap_done = 1'b1;
        st_nxt.async_mode = ~load_s;
      end
    end
    // Sleep is entered on request and left on the wake pin.
    if (sleep_enter_i)
      st_nxt.sleep = 1'b1;
    else if (!wake_s)
      st_nxt.sleep = 1'b0;
    case (st_r.phase)
      sdl_pkg::SDL_IDLE:
      begin
        st_nxt.bitcnt = '0;
        if (!cs_s)
          st_nxt.phase = sdl_pkg::SDL_SHIFT;
      end
      sdl_pkg::SDL_SHIFT:
      begin
        if (cs_s)
        begin
          st_nxt.phase = sdl_pkg::SDL_IDLE;
          st_nxt.bitcnt = '0;
          if (st_r.bitcnt == sdl_pkg::WORD_BITS && !st_r.sleep)
            st_nxt.data[wr_ch] = st_r.shreg[sdl_pkg::DATA_W-1:0];
        end
        else if (sclk_fall && !st_r.sleep)
        begin
          st_nxt.shreg = {st_r.shreg[sdl_pkg::WORD_W-2:0], sdi_s};
          if (st_r.bitcnt != sdl_pkg::WORD_BITS)
            st_nxt.bitcnt = st_r.bitcnt + 5'h01;
        end
      end
      default:
      begin
        st_nxt.phase = sdl_pkg::SDL_IDLE;
      end
    endcase
    // Serial output data.
    if (st_r.sleep)
      st_nxt.sdo = sdi_s;
    else if (sclk_rise || (st_r.cs_q && !cs_s))
      st_nxt.sdo = st_r.shreg[sdl_pkg::WORD_W-1];
    // Output enable follows select unless disabled.
    st_nxt.oe_n = serial_out_disable_i | cs_s;
    // Latches follow the data registers while latch load is low.
    if (!load_s)
      st_nxt.latch = st_r.data;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      st_r <= sdl_pkg::STATE_RST;
    else
      st_r <= st_nxt;
  end

  assign sdo_o = st_r.sdo;
  assign sdo_oe_n_o = st_r.oe_n;
  assign dac_value_o = st_r.latch;
  assign sleep_o = st_r.sleep;
  assign async_mode_o = st_r.async_mode;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_frame_end;
    frame_end && st_r.phase == sdl_pkg::SDL_SHIFT
      && st_r.bitcnt == sdl_pkg::WORD_BITS && !st_r.sleep;
  endsequence

  sequence s_load_fall;
    st_r.load_q && !load_s;
  endsequence

  a_sdo_disabled_hiz: assert property (
    serial_out_disable_i |=> sdo_oe_n_o)
    else $error("Serial output driven while disabled.");

  a_sdo_drive_on: assert property (
    (!serial_out_disable_i && !cs_s) |=> !sdo_oe_n_o)
    else $error("Serial output not driven in frame.");

  a_sdo_release: assert property (
    $rose(cs_s) |=> sdo_oe_n_o [*2])
    else $error("Serial output not released after select rise.");

  a_latch_follow: assert property (
    !load_s |=> dac_value_o == $past(st_r.data))
    else $error("Latch not transparent while load is low.");

  a_latch_hold: assert property (
    load_s |=> $stable(dac_value_o))
    else $error("Output value changed without a latch update.");

  a_load_fall: assert property (
    s_load_fall |=> dac_value_o == $past(st_r.data))
    else $error("Latch not loaded on latch load fall.");

  a_shift_fall: assert property (
    (sclk_fall && st_r.phase == sdl_pkg::SDL_SHIFT && !st_r.sleep)
      |=> st_r.shreg[0] == $past(sdi_s))
    else $error("Input bit not taken on clock fall.");

  a_sdo_rise: assert property (
    (sclk_rise && !st_r.sleep)
      |=> sdo_o == $past(st_r.shreg[sdl_pkg::WORD_W-1]))
    else $error("Output bit not updated on clock rise.");

  a_sleep_pass: assert property (
    st_r.sleep |=> sdo_o == $past(sdi_s))
    else $error("Sleep pass-through broken.");

  a_wake_exit: assert property (
    (!wake_s && !sleep_enter_i) |=> !sleep_o)
    else $error("Wake pin did not end sleep.");

  a_idle_ignore: assert property (
    (cs_s && st_r.phase == sdl_pkg::SDL_IDLE) |=> $stable(st_r.shreg))
    else $error("Shift register moved while select is high.");

  a_frame_write: assert property (
    s_frame_end |=> st_r.data[$past(wr_ch)]
      == $past(st_r.shreg[sdl_pkg::DATA_W-1:0]))
    else $error("Frame word not written at select rise.");

  a_chain_load: assert property (
    (daisy_chain_i && s_load_fall) |=> dac_value_o == $past(st_r.data))
    else $error("Latch not loaded on latch load fall in daisy chain.");

  a_short_frame: assert property (
    (cs_s && st_r.phase == sdl_pkg::SDL_SHIFT
      && st_r.bitcnt != sdl_pkg::WORD_BITS) |=> $stable(st_r.data))
    else $error("Short frame wrote a data register.");

  a_strap_pick: assert property (
    (!st_r.strap_done && st_r.strap_cnt == sdl_pkg::STRAP_WAIT)
      |=> async_mode_o == !$past(load_s))
    else $error("Update mode not taken from latch load level.");

  a_strap_hold: assert property (
    st_r.strap_done |=> $stable(async_mode_o))
    else $error("Update mode changed after power-up.");

endmodule : sdl_top

/* testbench/sdl_host.sv */
/*
  Host controller model: drives select, serial clock and data pins.
  Assumes calls start at falling core clock edges.
*/
`timescale 1ns/1ps
module sdl_host (
  input wire logic core_clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic [23:0] rx_o
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rx_o = 24'h000000;
  end
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask : half
  task automatic pins(input logic cs_n, input logic d);
    cs_n_o = cs_n;
    sdi_o = d;
  endtask : pins
  task automatic send(input logic [23:0] w);
    cs_n_o = 1'b0;
    half();
    for (int i = 23; i >= 0; i--)
    begin
      sdi_o = w[i];
      half();
      sclk_o = 1'b0;
      rx_o = {rx_o[22:0], sdo_i};
      half();
      sclk_o = 1'b1;
    end
    half();
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    half();
  endtask : send
endmodule : sdl_host

/* testbench/sdl_top_test.sv */
/*
  Self-checking bench for the serial load interface.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
module sdl_top_test;
  localparam int DW = sdl_pkg::CH_N * sdl_pkg::DATA_W;
  logic clk, rst, load_n, wake_n, dis, daisy, slp_in;
  logic sclk, cs_n, sdi, sdo, oe_n, slp, amode;
  logic [DW-1:0] dac, want;
  logic [23:0] rx;
  wire sdo_w;
  int num_errors, n_checks;
  assign sdo_w = oe_n ? 1'bz : sdo;
  sdl_top i_sdl_top (.core_clk_i(clk), .reset_i(rst), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .latch_load_n_i(load_n),
    .sleep_exit_n_i(wake_n), .serial_out_disable_i(dis),
    .daisy_chain_i(daisy), .sleep_enter_i(slp_in), .sdo_o(sdo),
    .sdo_oe_n_o(oe_n), .dac_value_o(dac), .sleep_o(slp),
    .async_mode_o(amode));
  sdl_host i_sdl_host (.core_clk_i(clk), .sdo_i(sdo_w), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdi_o(sdi), .rx_o(rx));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t ns saw %0h wanted %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic reset(input logic ld);
    load_n = ld;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(6);
  endtask : reset
  task automatic wr(input logic [2:0] ch, input logic [15:0] d);
    want[ch*16 +: 16] = d;
    i_sdl_host.send({5'h00, ch, d});
  endtask : wr
  task automatic t_sync();
    fork
      wr(3'h3, 16'hA5C3);
      begin
        cyc(8);
        check(oe_n, 1'b0);
      end
    join
    check(oe_n, 1'b1);
    check(dac, '0);
    load_n = 1'b0;
    cyc(4);
    check(dac, want);
    load_n = 1'b1;
  endtask : t_sync
  task automatic t_daisy();
    daisy = 1'b1;
    dis = 1'b1;
    fork
      wr(3'h5, 16'h0F1E);
      begin
        cyc(8);
        check(oe_n, 1'b1);
      end
    join
    check(rx, {24{1'bz}});
    dis = 1'b0;
    wr(3'h0, 16'hFFFF);
    check(rx, 24'h050F1E);
    check(dac[63:48], 16'hA5C3);
    check(dac[95:80], 16'h0000);
    load_n = 1'b0;
    cyc(4);
    check(dac, want);
    load_n = 1'b1;
  endtask : t_daisy
  task automatic t_sleep();
    slp_in = 1'b1;
    cyc(1);
    slp_in = 1'b0;
    cyc(2);
    check(slp, 1'b1);
    i_sdl_host.pins(1'b0, 1'b1);
    cyc(4);
    check(sdo, 1'b1);
    i_sdl_host.pins(1'b0, 1'b0);
    cyc(4);
    check(sdo, 1'b0);
    i_sdl_host.pins(1'b1, 1'b1);
    wake_n = 1'b0;
    cyc(4);
    check(slp, 1'b0);
    wake_n = 1'b1;
    cyc(4);
  endtask : t_sleep
  task automatic t_async();
    reset(1'b0);
    check(amode, 1'b1);
    want = '0;
    wr(3'h7, 16'h8001);
    cyc(2);
    check(dac, want);
  endtask : t_async
  initial
  begin
    load_n = 1'b1;
    wake_n = 1'b1;
    dis = 1'b0;
    daisy = 1'b0;
    slp_in = 1'b0;
    num_errors = 0;
    n_checks = 0;
    want = '0;
    reset(1'b1);
    check(oe_n, 1'b1);
    check(amode, 1'b0);
    t_sync();
    t_daisy();
    t_sleep();
    t_async();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : sdl_top_test
